// ### verilog/pmw_regs.vh
`ifndef PMW_REGS_VH
`define PMW_REGS_VH

// ==========================================================================
// Register addresses on the special-function bus.
`define PMW_ADDR_PWR_CTL     8'h87
`define PMW_ADDR_CLK_SEL     8'h8f
`define PMW_ADDR_WAKE_MASK   8'h9f
`define PMW_ADDR_PWR_MODE    8'hc4
`define PMW_ADDR_TA_B        8'hc9

// ==========================================================================
// Reset values.
`define PMW_RST_PWR_CTL      8'h00
`define PMW_RST_CLK_SEL      8'hc0
`define PMW_RST_WAKE_MASK    8'hff
`define PMW_RST_PWR_MODE     8'h40
`define PMW_RST_WDLY         3'h6

// ==========================================================================
// Field positions.
`define PMW_PC_IDLE_BIT      0
`define PMW_PC_STOP_BIT      1
`define PMW_PC_SLEEP_BIT     2
`define PMW_PC_BAUD_BIT      7
`define PMW_PM_DIV_MSB       7
`define PMW_PM_DIV_LSB       6
`define PMW_PM_AUTO_BIT      5
`define PMW_CS_WDLY_MSB      7
`define PMW_CS_WDLY_LSB      5
`define PMW_TB_STAT_BIT      0

// ==========================================================================
// Field codes and timed-access keys.
`define PMW_DIV_SLOW         2'b11
`define PMW_DIV_FULL         2'b01
`define PMW_TB_KEY1          8'haa
`define PMW_TB_KEY2          8'h55
`define PMW_TB_CLOSE         8'h00

// ==========================================================================
// Timing counts in system clock cycles.
`define PMW_TB_WINDOW        9'd256
`define PMW_SLOW_DIVIDE      257
`define PMW_WDLY_BASE        14'd64

`endif

// ### verilog/pmw_clk_div.v
`timescale 1ns/10ps

// ==========================================================================
// Slow clock enable: one tick every DIV cycles while running.
module pmw_clk_div #(
	parameter DIV = 257,
	parameter CW  = 9
) (
	// Clock and reset.
	input  wire          mclk,
	input  wire          resetn,
	// Control and tick.
	input  wire          run,
	output reg           tick_ff
);

	reg [CW-1:0] count_ff;
	reg [CW-1:0] nxt_count;

	// Counter restarts whenever the slow mode is off, so the first slow
	// tick always comes a full period after entry.
	always @* begin
		if (!run || count_ff == DIV[CW-1:0] - 1'b1)
			nxt_count = {CW{1'b0}};
		else
			nxt_count = count_ff + 1'b1;
	end

	// Tick register.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count_ff <= {CW{1'b0}};
			tick_ff  <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			tick_ff  <= run && (count_ff == DIV[CW-1:0] - 1'b1);
		end
	end

endmodule // pmw_clk_div

// ### verilog/pmw_wake_ctl.v
`timescale 1ns/10ps
`include "pmw_regs.vh"

module pmw_wake_ctl #(
	parameter DLYW = 14
) (
	// Clock and reset.
	input  wire       mclk,
	input  wire       resetn,
	// Special-function register port.
	input  wire [7:0] sfrAddr,
	input  wire       sfrWrite,
	input  wire [7:0] sfrWdata,
	output reg  [7:0] sfrRdata_ff,
	// Wake sources, one bit per line in wake mask order.
	input  wire [7:0] extIntPinLow,
	input  wire [7:0] asyncPeriphFlag,
	input  wire [7:0] intEnable,
	// Interrupt logic and reset events.
	input  wire       intAccepted,
	input  wire       watchdogReset,
	// Serial port zero events.
	input  wire       serialRxLine,
	input  wire       serialRxEnable,
	input  wire       serialTxLoad,
	// Clock and power controls.
	output reg        cpuClkEn_ff,
	output reg        periphClkEn_ff,
	output reg        internalOscEn_ff,
	output reg        mainRegOn_ff,
	output reg        wakeEvent_ff,
	output reg        dividedMode_ff,
	output reg        idleMode_ff,
	output reg        stopMode_ff,
	output reg        timedAccessOpen_ff,
	output reg        baudDouble_ff
);

	// ======================================================================
	// States, one-hot.
	localparam [3:0] ST_RUN  = 4'h1;
	localparam [3:0] ST_IDLE = 4'h2;
	localparam [3:0] ST_STOP = 4'h4;
	localparam [3:0] ST_WDLY = 4'h8;

	reg [3:0]      state_ff;
	reg [3:0]      nxt_state;
	reg            sleepSel_ff;
	reg [7:0]      wakeMask_ff;
	reg [1:0]      clkDivCtl_ff;
	reg            autoReturn_ff;
	reg [2:0]      wakeDelaySel_ff;
	reg [1:0]      clkSrcSel_ff;
	reg            tbArmed_ff;
	reg [8:0]      tbCount_ff;
	reg [7:0]      lineLvlPrev_ff;
	reg            rxPrev_ff;
	reg [DLYW-1:0] wdlyCount_ff;
	reg [DLYW-1:0] nxt_wdlyCount;
	reg [7:0]      nxt_rdata;
	reg [DLYW-1:0] wdlyLoad;

	wire       slowTick;
	wire [7:0] lineLvl;
	wire [7:0] lineRise;
	wire       stopWake;
	wire       idleWake;
	wire       rxStartFall;
	wire       autoBack;
	wire       wrPwrCtl;
	wire       wrPwrMode;
	wire       wrTb;
	wire       slowMode;

	// ======================================================================
	// Wake source conditioning.
	// Only pins and unclocked peripheral flags feed the wake path; clocked
	// peripheral interrupts are not wired in here at all.
	assign lineLvl  = ~extIntPinLow | asyncPeriphFlag;
	assign lineRise = lineLvl & ~lineLvlPrev_ff;
	// Enables are deliberately not consulted for stop wake, so a masked-in line
	// wakes the core from stop even when its interrupt will not be serviced.
	assign stopWake = |(lineRise & wakeMask_ff);
	assign idleWake = |(lineLvl & intEnable);

	// Auto return triggers; the serial interrupt itself plays no part.
	assign rxStartFall = rxPrev_ff & ~serialRxLine;
	assign autoBack = autoReturn_ff &&
		(intAccepted ||
		 (rxStartFall && serialRxEnable) ||
		 serialTxLoad);

	assign slowMode  = (clkDivCtl_ff == `PMW_DIV_SLOW);
	assign wrPwrCtl  = sfrWrite && sfrAddr == `PMW_ADDR_PWR_CTL;
	assign wrPwrMode = sfrWrite && sfrAddr == `PMW_ADDR_PWR_MODE;
	assign wrTb      = sfrWrite && sfrAddr == `PMW_ADDR_TA_B;

	// ======================================================================
	// Divided clock enable for the CPU only; the peripheral clock enable is not divided.
	pmw_clk_div #(
		.DIV (`PMW_SLOW_DIVIDE),
		.CW  (9)
	) u_div (
		.mclk    (mclk),
		.resetn  (resetn),
		.run     (slowMode),
		.tick_ff (slowTick)
	);

	// ======================================================================
	// Edge history for wake lines and the serial receive line.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lineLvlPrev_ff <= 8'h00;
			rxPrev_ff      <= 1'b1;
		end else begin
			lineLvlPrev_ff <= lineLvl;
			rxPrev_ff      <= serialRxLine;
		end
	end

	// ======================================================================
	// Timed-access B window. A repeated key pair restarts the full window.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tbArmed_ff <= 1'b0;
			tbCount_ff <= 9'd0;
		end else if (wrTb) begin
			tbArmed_ff <= (sfrWdata == `PMW_TB_KEY1);
			if (sfrWdata == `PMW_TB_CLOSE)
				tbCount_ff <= 9'd0;
			else if (tbArmed_ff && sfrWdata == `PMW_TB_KEY2)
				tbCount_ff <= `PMW_TB_WINDOW;
			else if (tbCount_ff != 9'd0)
				tbCount_ff <= tbCount_ff - 9'd1;
		end else if (tbCount_ff != 9'd0) begin
			tbCount_ff <= tbCount_ff - 9'd1;
		end
	end

	// ======================================================================
	// Protected registers: wake mask and wake delay / clock source select.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wakeMask_ff     <= `PMW_RST_WAKE_MASK;
			wakeDelaySel_ff <= `PMW_RST_WDLY;
			clkSrcSel_ff    <= 2'b00;
		end else if (sfrWrite && tbCount_ff != 9'd0) begin
			if (sfrAddr == `PMW_ADDR_WAKE_MASK)
				wakeMask_ff <= sfrWdata;
			if (sfrAddr == `PMW_ADDR_CLK_SEL) begin
				wakeDelaySel_ff <= sfrWdata[`PMW_CS_WDLY_MSB:
					`PMW_CS_WDLY_LSB];
				clkSrcSel_ff    <= sfrWdata[1:0];
			end
		end
	end

	// ======================================================================
	// Power mode register. Auto return drops back to the full-speed code,
	// so slow mode stays off until software writes the slow code again.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clkDivCtl_ff  <= `PMW_DIV_FULL;
			autoReturn_ff <= 1'b0;
		end else if (watchdogReset) begin
			clkDivCtl_ff  <= `PMW_DIV_FULL;
			autoReturn_ff <= 1'b0;
		end else if (wrPwrMode) begin
			clkDivCtl_ff  <= sfrWdata[`PMW_PM_DIV_MSB:
				`PMW_PM_DIV_LSB];
			autoReturn_ff <= sfrWdata[`PMW_PM_AUTO_BIT];
		end else if (slowMode && autoBack) begin
			clkDivCtl_ff  <= `PMW_DIV_FULL;
		end
	end

	// ======================================================================
	// Wake delay length: zero, or 128 doubling up to 8192 cycles.
	always @* begin
		if (wakeDelaySel_ff == 3'd0)
			wdlyLoad = {DLYW{1'b0}};
		else
			wdlyLoad = `PMW_WDLY_BASE << wakeDelaySel_ff;
	end

	// ======================================================================
	// Mode sequencer.
	always @* begin
		nxt_state     = state_ff;
		nxt_wdlyCount = wdlyCount_ff;
		case (state_ff)
			ST_RUN: begin
				if (wrPwrCtl && sfrWdata[`PMW_PC_STOP_BIT])
					nxt_state = ST_STOP;
				else if (wrPwrCtl && sfrWdata[`PMW_PC_IDLE_BIT])
					nxt_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (idleWake)
					nxt_state = ST_RUN;
			end
			ST_STOP: begin
				if (stopWake && sleepSel_ff && wdlyLoad != 0) begin
					nxt_state     = ST_WDLY;
					nxt_wdlyCount = wdlyLoad - 1'b1;
				end else if (stopWake) begin
					nxt_state = ST_RUN;
				end
			end
			ST_WDLY: begin
				if (wdlyCount_ff == {DLYW{1'b0}})
					nxt_state = ST_RUN;
				else
					nxt_wdlyCount = wdlyCount_ff - 1'b1;
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	// State, sleep selection and the mode flags software sees.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_ff      <= ST_RUN;
			sleepSel_ff   <= 1'b0;
			wdlyCount_ff  <= {DLYW{1'b0}};
			baudDouble_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			wdlyCount_ff <= nxt_wdlyCount;
			if (state_ff == ST_RUN && wrPwrCtl) begin
				sleepSel_ff   <= sfrWdata[`PMW_PC_SLEEP_BIT] &&
					sfrWdata[`PMW_PC_STOP_BIT];
				baudDouble_ff <= sfrWdata[`PMW_PC_BAUD_BIT];
			end else if (nxt_state == ST_RUN) begin
				sleepSel_ff <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Clock and power outputs. All changes land on a clock edge, so the
	// oscillator enable falls only between whole cycles, never mid-pulse.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cpuClkEn_ff        <= 1'b1;
			periphClkEn_ff     <= 1'b1;
			internalOscEn_ff   <= 1'b1;
			mainRegOn_ff       <= 1'b1;
			wakeEvent_ff       <= 1'b0;
			dividedMode_ff     <= 1'b0;
			idleMode_ff        <= 1'b0;
			stopMode_ff        <= 1'b0;
			timedAccessOpen_ff <= 1'b0;
		end else begin
			cpuClkEn_ff <= (nxt_state == ST_RUN) &&
				(!slowMode || slowTick);
			periphClkEn_ff <= (nxt_state == ST_RUN) ||
				(nxt_state == ST_IDLE);
			internalOscEn_ff <= (nxt_state != ST_STOP);
			mainRegOn_ff <= !(nxt_state == ST_STOP &&
				(sleepSel_ff || (wrPwrCtl && state_ff == ST_RUN &&
				sfrWdata[`PMW_PC_SLEEP_BIT])));
			// Tells the interrupt logic the core is back; it vectors
			// only if the waking line is itself enabled.
			wakeEvent_ff <= (state_ff != ST_RUN) &&
				(nxt_state == ST_RUN);
			dividedMode_ff <= slowMode;
			idleMode_ff <= (nxt_state == ST_IDLE);
			stopMode_ff <= (nxt_state == ST_STOP) ||
				(nxt_state == ST_WDLY);
			timedAccessOpen_ff <= (tbCount_ff != 9'd0);
		end
	end

	// ======================================================================
	// Register read-back, one cycle after the address. Request bits of the
	// power control register are write-only and read as zero.
	always @* begin
		nxt_rdata = 8'h00;
		case (sfrAddr)
			`PMW_ADDR_PWR_CTL:
				nxt_rdata[`PMW_PC_BAUD_BIT] = baudDouble_ff;
			`PMW_ADDR_PWR_MODE: begin
				nxt_rdata[`PMW_PM_DIV_MSB:`PMW_PM_DIV_LSB] =
					clkDivCtl_ff;
				nxt_rdata[`PMW_PM_AUTO_BIT] = autoReturn_ff;
			end
			`PMW_ADDR_WAKE_MASK: nxt_rdata = wakeMask_ff;
			`PMW_ADDR_CLK_SEL: begin
				nxt_rdata[`PMW_CS_WDLY_MSB:`PMW_CS_WDLY_LSB] =
					wakeDelaySel_ff;
				nxt_rdata[1:0] = clkSrcSel_ff;
			end
			`PMW_ADDR_TA_B:
				nxt_rdata[`PMW_TB_STAT_BIT] = (tbCount_ff != 9'd0);
			default: nxt_rdata = 8'h00;
		endcase
	end

	// Read data register.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			sfrRdata_ff <= 8'h00;
		else
			sfrRdata_ff <= nxt_rdata;
	end

endmodule // pmw_wake_ctl

// ### bench/pmw_wake_ctl_assertions.sv
`timescale 1ns/10ps

// ==========================================================================
// Port checks of the power mode and wake controller.
module pmw_wake_ctl_chk (
	// Clock and reset.
	input wire       mclk,
	input wire       resetn,
	// Register port and events.
	input wire [7:0] sfrAddr,
	input wire       sfrWrite,
	input wire [7:0] sfrWdata,
	input wire [7:0] extIntPinLow,
	input wire [7:0] asyncPeriphFlag,
	input wire [7:0] intEnable,
	input wire       intAccepted,
	input wire       watchdogReset,
	input wire       serialTxLoad,
	// Clock and mode outputs.
	input wire       cpuClkEn_ff,
	input wire       periphClkEn_ff,
	input wire       internalOscEn_ff,
	input wire       mainRegOn_ff,
	input wire       wakeEvent_ff,
	input wire       dividedMode_ff,
	input wire       idleMode_ff,
	input wire       stopMode_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	reg        autoRet_ff;
	reg  [8:0] gap_ff;
	reg        seen_ff;
	wire       run = !stopMode_ff && !idleMode_ff;
	wire       pcWr = sfrWrite && sfrAddr == 8'h87 && run;
	wire       slowWr = sfrWrite && sfrAddr == 8'hc4 && sfrWdata[7:6] == 2'b11;
	// Shadow of auto return; gap is only trusted after one real slow tick.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			autoRet_ff <= 1'b0;
			gap_ff <= 9'h000;
			seen_ff <= 1'b0;
		end else begin
			if (watchdogReset)
				autoRet_ff <= 1'b0;
			else if (sfrWrite && sfrAddr == 8'hc4)
				autoRet_ff <= sfrWdata[5];
			gap_ff <= cpuClkEn_ff ? 9'h000 : gap_ff + 9'h001;
			seen_ff <= dividedMode_ff && run &&
				(seen_ff || (cpuClkEn_ff && gap_ff != 9'h000));
		end
	end
	sequence sStopped;
		stopMode_ff && !internalOscEn_ff && !cpuClkEn_ff && !periphClkEn_ff;
	endsequence
	sequence sResumed;
		cpuClkEn_ff && internalOscEn_ff && !stopMode_ff && !idleMode_ff;
	endsequence
	chk_stop_entry: assert property (pcWr && sfrWdata[1] |=> sStopped)
		else $error("stop request left a clock running");
	chk_sleep_regulator: assert property (
		pcWr && sfrWdata[2:1] == 2'b11 |=> !mainRegOn_ff)
		else $error("sleep request left the regulator on");
	chk_idle_entry: assert property (pcWr && sfrWdata[1:0] == 2'b01
		|=> idleMode_ff && !cpuClkEn_ff && periphClkEn_ff)
		else $error("idle entry gated the wrong clocks");
	chk_osc_gated: assert property (
		!internalOscEn_ff |-> stopMode_ff && !cpuClkEn_ff && !periphClkEn_ff)
		else $error("clock enabled with oscillator off");
	chk_wake_once: assert property (
		$rose(wakeEvent_ff) |-> sResumed ##1 !wakeEvent_ff)
		else $error("wake pulse wrong");
	chk_idle_exit: assert property (idleMode_ff &&
		|((~extIntPinLow | asyncPeriphFlag) & intEnable)
		|-> ##[1:2] (!idleMode_ff && wakeEvent_ff))
		else $error("idle did not end on enabled line");
	chk_slow_period: assert property (
		dividedMode_ff && cpuClkEn_ff && seen_ff |-> gap_ff == 9'd256)
		else $error("slow tick period wrong");
	// The mode flag is a registered copy of the divider code, so it
	// trails the code by one cycle: exits show two edges after the cause.
	chk_auto_return: assert property (
		dividedMode_ff && autoRet_ff && (serialTxLoad || intAccepted)
		|-> ##2 !dividedMode_ff)
		else $error("auto return missed");
	chk_wdog_exit: assert property (
		watchdogReset |-> ##2 !dividedMode_ff)
		else $error("watchdog left slow mode on");
	chk_no_reentry: assert property (
		$rose(dividedMode_ff) |-> $past(slowWr, 2))
		else $error("slow mode entered without a write");
endmodule // pmw_wake_ctl_chk

bind pmw_wake_ctl pmw_wake_ctl_chk pmw_wake_ctl_chk_inst (
	.mclk(mclk), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
	.sfrWdata(sfrWdata), .extIntPinLow(extIntPinLow),
	.asyncPeriphFlag(asyncPeriphFlag), .intEnable(intEnable),
	.intAccepted(intAccepted), .watchdogReset(watchdogReset),
	.serialTxLoad(serialTxLoad), .cpuClkEn_ff(cpuClkEn_ff),
	.periphClkEn_ff(periphClkEn_ff), .internalOscEn_ff(internalOscEn_ff),
	.mainRegOn_ff(mainRegOn_ff), .wakeEvent_ff(wakeEvent_ff),
	.dividedMode_ff(dividedMode_ff), .idleMode_ff(idleMode_ff),
	.stopMode_ff(stopMode_ff));

// ### bench/pmw_cpu_model.sv
`timescale 1ns/10ps

// ==========================================================================
// Core model: accepts enabled line interrupts, idles after a wake.
module pmw_cpu_model #(
	parameter [9:0] NOPS = 10'h1f4
) (
	// Clock and reset.
	input  wire       mclk,
	input  wire       resetn,
	// Device and pin side.
	input  wire       cpuClkEn,
	input  wire       wakeEvent,
	input  wire [7:0] extIntPinLow,
	input  wire [7:0] intEnable,
	// Interrupt logic and software state.
	output reg        intAccepted_ff,
	output wire       nopHold
);
	reg  [7:0] taken_ff;
	reg  [9:0] nopCnt_ff;
	wire [7:0] req = ~extIntPinLow & intEnable & ~taken_ff;
	assign nopHold = |nopCnt_ff;
	// One acceptance per low period, and only while the core is clocked.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			intAccepted_ff <= 1'b0;
			taken_ff <= 8'h00;
			nopCnt_ff <= 10'h000;
		end else begin
			intAccepted_ff <= cpuClkEn && |req;
			taken_ff <= (taken_ff | (cpuClkEn ? req : 8'h00)) & ~extIntPinLow;
			nopCnt_ff <= wakeEvent ? NOPS : nopCnt_ff - {9'h000, nopHold};
		end
	end
endmodule // pmw_cpu_model

// ### bench/pmw_wake_ctl_bench.sv
`timescale 1ns/10ps

// ==========================================================================
// Self-checking bench of the power mode and wake controller.
module pmw_wake_ctl_bench;
	reg        mclk, resetn, sfrWrite, watchdogReset;
	reg        serialRxLine, serialRxEnable, serialTxLoad, probe, pend;
	reg  [7:0] sfrAddr, sfrWdata, extIntPinLow, asyncPeriphFlag, intEnable;
	reg  [7:0] m, obs;
	reg  [8:0] e;
	reg  [8:0] expQ[$];
	integer    mismatches, n_tests, seed, i, code, dly;
	wire [7:0] sfrRdata_ff;
	wire       cpuClkEn_ff, periphClkEn_ff, internalOscEn_ff, mainRegOn_ff;
	wire       wakeEvent_ff, dividedMode_ff, idleMode_ff, stopMode_ff;
	wire       timedAccessOpen_ff, intAccepted, nopHold, baudDouble_ff;
	wire [7:0] status = {baudDouble_ff, mainRegOn_ff, internalOscEn_ff,
		stopMode_ff,
		idleMode_ff, dividedMode_ff, periphClkEn_ff, timedAccessOpen_ff};
	pmw_wake_ctl pmw_wake_ctl_inst (.mclk(mclk), .resetn(resetn),
		.sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata),
		.sfrRdata_ff(sfrRdata_ff), .extIntPinLow(extIntPinLow),
		.asyncPeriphFlag(asyncPeriphFlag), .intEnable(intEnable),
		.intAccepted(intAccepted), .watchdogReset(watchdogReset),
		.serialRxLine(serialRxLine), .serialRxEnable(serialRxEnable),
		.serialTxLoad(serialTxLoad), .cpuClkEn_ff(cpuClkEn_ff),
		.periphClkEn_ff(periphClkEn_ff), .internalOscEn_ff(internalOscEn_ff),
		.mainRegOn_ff(mainRegOn_ff), .wakeEvent_ff(wakeEvent_ff),
		.dividedMode_ff(dividedMode_ff), .idleMode_ff(idleMode_ff),
		.stopMode_ff(stopMode_ff), .timedAccessOpen_ff(timedAccessOpen_ff),
		.baudDouble_ff(baudDouble_ff));
	pmw_cpu_model pmw_cpu_model_inst (.mclk(mclk), .resetn(resetn),
		.cpuClkEn(cpuClkEn_ff), .wakeEvent(wakeEvent_ff),
		.extIntPinLow(extIntPinLow), .intEnable(intEnable),
		.intAccepted_ff(intAccepted), .nopHold(nopHold));
	// Free-running 25 MHz clock.
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;
	// Oldest note is compared once its result has been registered.
	always @(posedge mclk) begin
		if (pend) begin
			e = expQ.pop_front();
			obs = e[8] ? status : sfrRdata_ff;
			n_tests = n_tests + 1;
			if (obs !== e[7:0]) begin
				mismatches = mismatches + 1;
				$display("mismatch %s exp %h got %h", e[8] ? "status" : "rdata",
					e[7:0], obs);
			end
		end
		pend <= probe;
	end
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge mclk);
			sfrAddr = a;
			sfrWdata = d;
			sfrWrite = 1'b1;
			@(negedge mclk);
			sfrWrite = 1'b0;
		end
	endtask
	task chk(input kind, input [7:0] a, input [7:0] ev);
		begin
			@(negedge mclk);
			if (!kind)
				sfrAddr = a;
			probe = 1'b1;
			expQ.push_back({kind, ev});
			@(negedge mclk);
			probe = 1'b0;
		end
	endtask
	task unlock;
		begin
			wr(8'hc9, 8'haa);
			wr(8'hc9, 8'h55);
		end
	endtask
	// Bounded wait for the wake pulse; running out counts as a mismatch.
	task waitWake(input integer lim);
		integer k;
		begin
			k = 0;
			while (wakeEvent_ff !== 1'b1 && k < lim) begin
				@(negedge mclk);
				k = k + 1;
			end
			if (wakeEvent_ff !== 1'b1) begin
				mismatches = mismatches + 1;
				$display("mismatch wakeEvent exp 1 got 0");
			end
		end
	endtask
	task results;
		begin
			$display("tests %0d mismatches %0d", n_tests, mismatches);
			if (mismatches == 0 && n_tests > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial begin
		#2400000;
		mismatches = mismatches + 1;
		results;
	end
	initial begin
		{mismatches, n_tests, probe, pend, sfrWrite, watchdogReset} = 0;
		{serialRxEnable, serialTxLoad, sfrAddr, sfrWdata} = 0;
		{asyncPeriphFlag, intEnable} = 16'h0000;
		extIntPinLow = 8'hff;
		serialRxLine = 1'b1;
		seed = 76;
		resetn = 1'b0;
		repeat (6) @(negedge mclk);
		resetn = 1'b1;
		chk(0, 8'h9f, 8'hff);
		chk(0, 8'hc4, 8'h40);
		chk(0, 8'h8f, 8'hc0);
		chk(0, 8'h87, 8'h00);
		chk(0, 8'h10, 8'h00);
		chk(1, 8'h00, 8'h62);
		// Baud doubling is the one power control bit that reads back.
		wr(8'h87, 8'h80);
		chk(0, 8'h87, 8'h80);
		chk(1, 8'h00, 8'he2);
		// Wake mask: locked, unlocked, closed by key, then expired.
		m = ($random(seed) | 8'h01) & 8'h7f;
		wr(8'h9f, m);
		chk(0, 8'h9f, 8'hff);
		unlock;
		wr(8'h9f, m);
		chk(0, 8'h9f, m);
		chk(1, 8'h00, 8'he3);
		wr(8'hc9, 8'h00);
		wr(8'h9f, 8'hff);
		chk(0, 8'h9f, m);
		unlock;
		repeat (260) @(negedge mclk);
		wr(8'h9f, 8'hff);
		chk(0, 8'h9f, m);
		// Stop: masked line, pin wake without enable, level, then flag.
		wr(8'h87, 8'h02);
		chk(1, 8'h00, 8'h50);
		extIntPinLow[7] = 1'b0;
		repeat (4) @(negedge mclk);
		chk(1, 8'h00, 8'h50);
		extIntPinLow = 8'hfe;
		waitWake(8);
		chk(1, 8'h00, 8'h62);
		chk(0, 8'h87, 8'h00);
		wr(8'h87, 8'h02);
		repeat (4) @(negedge mclk);
		chk(1, 8'h00, 8'h50);
		// Pin goes quiet first, so the flag makes a fresh rising edge.
		extIntPinLow[0] = 1'b1;
		@(negedge mclk);
		asyncPeriphFlag[0] = 1'b1;
		waitWake(8);
		asyncPeriphFlag[0] = 1'b0;
		// Sleep with every wake delay code.
		for (code = 0; code < 8; code = code + 1) begin
			dly = (code == 0) ? 0 : (64 << code);
			unlock;
			wr(8'h8f, {code[2:0], 5'h00});
			wr(8'hc9, 8'h00);
			wr(8'h87, 8'h06);
			chk(1, 8'h00, 8'h10);
			extIntPinLow[0] = 1'b0;
			if (code != 0) begin
				repeat (dly - 4) @(negedge mclk);
				chk(1, 8'h00, 8'h70);
			end
			waitWake(16);
			chk(1, 8'h00, 8'h62);
			extIntPinLow[0] = 1'b1;
			while (nopHold) @(negedge mclk);
		end
		// Idle: disabled line keeps idling, enabling it wakes.
		wr(8'h87, 8'h01);
		chk(1, 8'h00, 8'h6a);
		extIntPinLow[1] = 1'b0;
		repeat (4) @(negedge mclk);
		chk(1, 8'h00, 8'h6a);
		intEnable[1] = 1'b1;
		waitWake(8);
		chk(0, 8'h87, 8'h00);
		chk(1, 8'h00, 8'h62);
		// Slow mode left by each of its exits, the last a pin reset.
		for (i = 0; i < 6; i = i + 1) begin
			extIntPinLow = 8'hff;
			intEnable = 8'h00;
			serialRxEnable = 1'b0;
			wr(8'hc4, 8'he0);
			chk(1, 8'h00, 8'h66);
			repeat (600) @(negedge mclk);
			case (i)
			0: wr(8'hc4, 8'h60);
			1: serialTxLoad = 1'b1;
			2: begin
				serialRxLine = 1'b0;
				repeat (4) @(negedge mclk);
				chk(1, 8'h00, 8'h66);
				serialRxLine = 1'b1;
				serialRxEnable = 1'b1;
				@(negedge mclk);
				serialRxLine = 1'b0;
			end
			3: {extIntPinLow[2], intEnable[2]} = 2'b01;
			4: watchdogReset = 1'b1;
			default: begin
				resetn = 1'b0;
				@(negedge mclk);
				resetn = 1'b1;
			end
			endcase
			@(negedge mclk);
			{serialTxLoad, watchdogReset, serialRxLine} = 3'b001;
			repeat (300) @(negedge mclk);
			chk(1, 8'h00, 8'h62);
			chk(0, 8'hc4, (i >= 4) ? 8'h40 : 8'h60);
		end
		results;
	end
endmodule // pmw_wake_ctl_bench
